// [src/hasd_pkg.sv]
package hasd_pkg;

  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned LOW_ADDR_W = 12;
  localparam int unsigned SYNC_W     = ADDR_W + DATA_W + 1;

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_DOUT    = 8'h04;
  localparam logic [7:0] REG_DIN     = 8'h08;
  localparam logic [7:0] REG_ADDR    = 8'h0c;
  localparam logic [7:0] REG_CONFIG  = 8'h10;

  localparam int unsigned CTRL_DRIVE_BIT  = 0;
  localparam int unsigned CFG_CLK_LSB     = 0;
  localparam int unsigned CFG_STRAP_BIT   = 2;
  localparam int unsigned CFG_BUSY_BIT    = 3;
  localparam int unsigned CFG_BOOT_LSB    = 4;
  localparam int unsigned CFG_MHZ_LSB     = 8;
  localparam int unsigned CFG_LARGE_BIT   = 16;
  localparam int unsigned CFG_ROLE_BIT    = 17;

  localparam logic [7:0] MHZ_SEL_00 = 8'h0a;
  localparam logic [7:0] MHZ_SEL_01 = 8'h14;
  localparam logic [7:0] MHZ_SEL_10 = 8'h0c;
  localparam logic [7:0] MHZ_SEL_11 = 8'h10;

  typedef enum logic [3:0] {
    BOOT_NONE      = 4'b0001,
    BOOT_IDLE      = 4'b0010,
    BOOT_BC        = 4'b0100,
    BOOT_RT_ONLINE = 4'b1000
  } hasd_boot_t;

  typedef struct packed {
    logic              strap_en;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } hasd_pins_t;

  typedef struct packed {
    hasd_boot_t        boot;
    logic [1:0]        clk_sel;
    logic              strap_en;
    logic              rt_busy;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] dout;
    logic              drive;
    logic              ack;
    logic [31:0]       rdat;
  } hasd_state_t;

  localparam hasd_boot_t        RST_BOOT    = BOOT_NONE;
  localparam logic [1:0]        RST_CLK_SEL = 2'h0;
  localparam logic [ADDR_W-1:0] RST_ADDR    = 16'h0000;
  localparam logic [DATA_W-1:0] RST_DATA    = 16'h0000;
  localparam logic [31:0]       RST_RDAT    = 32'h0000_0000;

endpackage

// [src/hasd_sync.sv]
`timescale 1ns/100ps
module hasd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] stage1;

  // Two-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    stage1 <= d_i;
    q_o    <= stage1;
  end

endmodule

// [src/hasd_top.sv]
`timescale 1ns/100ps
// Overview of operation
// - Sixteen-bit two-way host data path.
// - Large-memory part decodes all sixteen address lines.
// - Small part, strap high: top lines address.
// - Small part, strap low: top two lines pick clock.
// - Strap high: third line is address 13.
// - Boot high, terminal-only part starts idle.
// - Boot high, full-role part starts controller.
// - Boot low: terminal online with busy set.
// - Low twelve lines always low address.
module hasd_top #(
  parameter bit LARGE_MEM = 1'b0,
  parameter bit FULL_ROLE = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] host_address_lines_i,
  input  wire logic        upper_addr_strap_enable_i,
  input  wire logic [15:0] host_data_lines_i,
  output logic      [15:0] host_data_lines_o,
  output logic      [15:0] host_data_lines_oe_o,
  output logic      [15:0] host_addr_decoded_o,
  output logic      [1:0]  clk_freq_sel_o,
  output logic      [3:0]  boot_mode_o,
  output logic             rt_busy_o,
  output logic             upper_addr_mode_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  hasd_pkg::hasd_pins_t  pins_raw;
  hasd_pkg::hasd_pins_t  pins;
  hasd_pkg::hasd_state_t st;
  hasd_pkg::hasd_state_t next_st;

  assign pins_raw.addr     = host_address_lines_i;
  assign pins_raw.data     = host_data_lines_i;
  assign pins_raw.strap_en = upper_addr_strap_enable_i;

  hasd_sync #(
    .W (hasd_pkg::SYNC_W)
  ) u_sync (
    .clk_i (clk_i),
    .d_i   (pins_raw),
    .q_o   (pins)
  );

  // Maps the pins onto the sixteen-bit host address for the held strap.
  function automatic logic [15:0] decode_addr(
    input logic [15:0] a,
    input logic        strap_en
  );
    logic [15:0] r;
    // On the small part with the strap low the top four lines are straps, so they read as zero.
    r = 16'h0000;
    r[11:0] = a[11:0];
    if (LARGE_MEM) begin
      r = a;
    end else if (strap_en) begin
      r[15:14] = a[15:14];
      r[13]    = a[13];
      r[12]    = a[12];
    end
    return r;
  endfunction

  // Clock frequency in MHz for a select code.
  function automatic logic [7:0] sel_mhz(input logic [1:0] s);
    logic [7:0] m;
    m = hasd_pkg::MHZ_SEL_00;
    case (s)
      2'h0:    m = hasd_pkg::MHZ_SEL_00;
      2'h1:    m = hasd_pkg::MHZ_SEL_01;
      2'h2:    m = hasd_pkg::MHZ_SEL_10;
      2'h3:    m = hasd_pkg::MHZ_SEL_11;
      default: m = hasd_pkg::MHZ_SEL_00;
    endcase
    return m;
  endfunction

  // Merges write data into a register under the byte enables.
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0]  sel
  );
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  logic        req;
  logic [31:0] cfg_word;

  always_comb begin
    next_st = st;
    req     = wb_cyc_i && wb_stb_i && !st.ack;

    if (rst_i) begin
      next_st.strap_en = pins.strap_en;
      next_st.clk_sel  = hasd_pkg::RST_CLK_SEL;
      next_st.boot     = hasd_pkg::BOOT_NONE;
      next_st.rt_busy  = 1'b0;
      if (!LARGE_MEM && !pins.strap_en) begin
        next_st.clk_sel = pins.addr[15:14];
        // The third line is tied high by the board, so only A12 picks the boot.
        if (pins.addr[12]) begin
          next_st.boot = FULL_ROLE ? hasd_pkg::BOOT_BC : hasd_pkg::BOOT_IDLE;
        end else begin
          next_st.boot    = hasd_pkg::BOOT_RT_ONLINE;
          next_st.rt_busy = 1'b1;
        end
      end
      next_st.addr  = hasd_pkg::RST_ADDR;
      next_st.din   = hasd_pkg::RST_DATA;
      next_st.dout  = hasd_pkg::RST_DATA;
      next_st.drive = 1'b0;
      next_st.ack   = 1'b0;
      next_st.rdat  = hasd_pkg::RST_RDAT;
    end else begin
      next_st.addr = decode_addr(pins.addr, st.strap_en);
      next_st.din  = pins.data;
      next_st.ack  = req;
      if (req && wb_we_i) begin
        case (wb_adr_i)
          hasd_pkg::REG_CTRL: begin
            if (wb_sel_i[0]) begin
              next_st.drive = wb_dat_i[hasd_pkg::CTRL_DRIVE_BIT];
            end
          end
          hasd_pkg::REG_DOUT: begin
            next_st.dout = merge16(st.dout, wb_dat_i, wb_sel_i);
          end
          default: begin
            next_st.dout = st.dout;
          end
        endcase
      end
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          hasd_pkg::REG_CTRL:   next_st.rdat = {31'h0000_0000, st.drive};
          hasd_pkg::REG_DOUT:   next_st.rdat = {16'h0000, st.dout};
          hasd_pkg::REG_DIN:    next_st.rdat = {16'h0000, st.din};
          hasd_pkg::REG_ADDR:   next_st.rdat = {16'h0000, st.addr};
          hasd_pkg::REG_CONFIG: next_st.rdat = cfg_word;
          default:              next_st.rdat = 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[hasd_pkg::CFG_CLK_LSB +: 2]  = st.clk_sel;
    cfg_word[hasd_pkg::CFG_STRAP_BIT]     = st.strap_en;
    cfg_word[hasd_pkg::CFG_BUSY_BIT]      = st.rt_busy;
    cfg_word[hasd_pkg::CFG_BOOT_LSB +: 4] = st.boot;
    cfg_word[hasd_pkg::CFG_MHZ_LSB +: 8]  = sel_mhz(st.clk_sel);
    cfg_word[hasd_pkg::CFG_LARGE_BIT]     = LARGE_MEM;
    cfg_word[hasd_pkg::CFG_ROLE_BIT]      = FULL_ROLE;
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // Every pin-side port leaves a flip-flop, one register behind the state; wb_dat_o and wb_ack_o come straight from the state.
  logic [15:0] data_out_q;
  logic [15:0] data_oe_q;
  logic [15:0] addr_q;
  logic [1:0]  clk_q;
  logic [3:0]  boot_q;
  logic        busy_q;
  logic        mode_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_out_q <= hasd_pkg::RST_DATA;
      data_oe_q  <= 16'h0000;
      addr_q     <= hasd_pkg::RST_ADDR;
      clk_q      <= hasd_pkg::RST_CLK_SEL;
      boot_q     <= hasd_pkg::RST_BOOT;
      busy_q     <= 1'b0;
      mode_q     <= 1'b0;
    end else begin
      data_out_q <= st.dout;
      data_oe_q  <= {16{st.drive}};
      addr_q     <= st.addr;
      clk_q      <= st.clk_sel;
      boot_q     <= st.boot;
      busy_q     <= st.rt_busy;
      mode_q     <= LARGE_MEM || st.strap_en;
    end
  end

  assign host_data_lines_o    = data_out_q;
  assign host_data_lines_oe_o = data_oe_q;
  assign host_addr_decoded_o  = addr_q;
  assign clk_freq_sel_o       = clk_q;
  assign boot_mode_o          = boot_q;
  assign rt_busy_o            = busy_q;
  assign upper_addr_mode_o    = mode_q;
  assign wb_dat_o             = st.rdat;
  assign wb_ack_o             = st.ack;

endmodule

// [tb/hasd_assertions.sv]
`timescale 1ns/100ps
module hasd_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] host_address_lines_i,
  input wire logic [15:0] host_data_lines_oe_o,
  input wire logic [15:0] host_addr_decoded_o,
  input wire logic [1:0]  clk_freq_sel_o,
  input wire logic [3:0]  boot_mode_o,
  input wire logic        rt_busy_o,
  input wire logic        upper_addr_mode_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  logic [2:0] age;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Counts edges since reset so the sync pipeline has settled.
  always_ff @(posedge clk_i) begin
    age <= rst_i ? 3'h0 : age + {2'h0, age != 3'h7};
  end
  oe_uniform_a: assert property (host_data_lines_oe_o == {16{host_data_lines_oe_o[0]}})
    else $error("Data enables differ.");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("No ack one cycle after request.");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack longer than one cycle.");
  low_addr_a: assert property (age > 3'h2 |-> host_addr_decoded_o[11:0] == $past(host_address_lines_i[11:0], 4))
    else $error("Low address wrong.");
  top_addr_a: assert property (upper_addr_mode_o && age > 3'h2 |->
    host_addr_decoded_o[15:12] == $past(host_address_lines_i[15:12], 4))
    else $error("Top address wrong.");
  strap_top_a: assert property (!upper_addr_mode_o && age > 3'h0 |-> host_addr_decoded_o[15:12] == 4'h0)
    else $error("Strap lines decoded as address.");
  cfg_hold_a: assert property (age > 3'h1 |-> $stable({clk_freq_sel_o, boot_mode_o, rt_busy_o}))
    else $error("Strap configuration moved.");
  busy_online_a: assert property (rt_busy_o == (boot_mode_o == 4'b1000))
    else $error("Busy does not match online boot.");
  addr_mode_a: assert property (upper_addr_mode_o |-> boot_mode_o == 4'b0001 && clk_freq_sel_o == 2'h0)
    else $error("Straps used in address mode.");
endmodule
bind hasd_top hasd_checker i_hasd_checker (.clk_i, .rst_i, .host_address_lines_i, .host_data_lines_oe_o,
  .host_addr_decoded_o, .clk_freq_sel_o, .boot_mode_o, .rt_busy_o, .upper_addr_mode_o, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o);

// [tb/hasd_host_model.sv]
`timescale 1ns/100ps
module hasd_host_model (
  input  wire logic        strap_en_i,
  input  wire logic [15:0] addr_want_i,
  input  wire logic [15:0] data_want_i,
  input  wire logic [15:0] dev_data_i,
  input  wire logic [15:0] dev_oe_i,
  output logic      [15:0] addr_o,
  output logic      [15:0] data_o,
  output logic             select_n_o
);
  // The host keeps the device selected for every transfer.
  assign select_n_o = 1'b0;
  // With the strap low the board ties the third address line high.
  assign addr_o = strap_en_i ? addr_want_i : (addr_want_i | 16'h2000);
  // A data line carries the device value while its enable is high.
  assign data_o = (dev_oe_i & dev_data_i) | (~dev_oe_i & data_want_i);
endmodule

// [tb/tb_host_address_strap_decode.sv]
`timescale 1ns/100ps
module tb_host_address_strap_decode;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        strap = 1'b0;
  logic [15:0] aw    = 16'h0000;
  logic [15:0] dw    = 16'h0000;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] q, rdat;
  logic [15:0] pin_a, pin_d, dout, oe, dec;
  logic [1:0]  csel;
  logic [3:0]  boot;
  logic        busy, mode, ack;
  logic [3:0]  sel   = 4'h0;
  logic [15:0] dec_l;
  logic [1:0]  csel_r;
  logic [3:0]  boot_l, boot_r;
  logic        mode_l, busy_r;
  int          errors = 0;
  int          compares = 0;
  logic [7:0]  mhz [4] = '{8'h0a, 8'h14, 8'h0c, 8'h10};
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  hasd_top i_hasd_top (.clk_i(clk_i), .rst_i(rst_i), .host_address_lines_i(pin_a), .upper_addr_strap_enable_i(strap),
    .host_data_lines_i(pin_d), .host_data_lines_o(dout), .host_data_lines_oe_o(oe), .host_addr_decoded_o(dec),
    .clk_freq_sel_o(csel), .boot_mode_o(boot), .rt_busy_o(busy), .upper_addr_mode_o(mode), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  hasd_host_model i_hasd_host_model (.strap_en_i(strap), .addr_want_i(aw), .data_want_i(dw), .dev_data_i(dout),
    .dev_oe_i(oe), .addr_o(pin_a), .data_o(pin_d), .select_n_o());
  hasd_top #(.LARGE_MEM(1'b1), .FULL_ROLE(1'b0)) i_hasd_top_large (.clk_i(clk_i), .rst_i(rst_i),
    .host_address_lines_i(pin_a), .upper_addr_strap_enable_i(strap), .host_data_lines_i(pin_d),
    .host_data_lines_o(), .host_data_lines_oe_o(), .host_addr_decoded_o(dec_l), .clk_freq_sel_o(),
    .boot_mode_o(boot_l), .rt_busy_o(), .upper_addr_mode_o(mode_l), .wb_cyc_i(1'b0), .wb_stb_i(1'b0),
    .wb_we_i(1'b0), .wb_adr_i(8'h00), .wb_sel_i(4'h0), .wb_dat_i(32'h0), .wb_dat_o(), .wb_ack_o());
  hasd_top #(.LARGE_MEM(1'b0), .FULL_ROLE(1'b0)) i_hasd_top_rt (.clk_i(clk_i), .rst_i(rst_i),
    .host_address_lines_i(pin_a), .upper_addr_strap_enable_i(strap), .host_data_lines_i(pin_d),
    .host_data_lines_o(), .host_data_lines_oe_o(), .host_addr_decoded_o(), .clk_freq_sel_o(csel_r),
    .boot_mode_o(boot_r), .rt_busy_o(busy_r), .upper_addr_mode_o(), .wb_cyc_i(1'b0), .wb_stb_i(1'b0),
    .wb_we_i(1'b0), .wb_adr_i(8'h00), .wb_sel_i(4'h0), .wb_dat_i(32'h0), .wb_dat_o(), .wb_ack_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic boot_up(input logic s, input logic [15:0] a);
    @(posedge clk_i);
    strap <= s;
    aw <= a;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      boot_up(1'b0, {i[1:0], 1'b1, i[2], 12'h5a5});
      chk(csel, i[1:0]);
      chk(csel_r, i[1:0]);
      chk(mode, 1'b0);
      chk(boot, i[2] ? hasd_pkg::BOOT_BC : hasd_pkg::BOOT_RT_ONLINE);
      chk(boot_r, i[2] ? hasd_pkg::BOOT_IDLE : hasd_pkg::BOOT_RT_ONLINE);
      chk(busy, !i[2]);
      chk(busy_r, !i[2]);
      chk(boot_l, hasd_pkg::BOOT_NONE);
      chk(mode_l, 1'b1);
      wb(1'b0, hasd_pkg::REG_CONFIG, 32'h0, 4'hf);
      chk(q[15:8], mhz[i[1:0]]);
      chk(dec, {4'h0, 12'h5a5});
      chk(dec_l, {i[1:0], 1'b1, i[2], 12'h5a5});
    end
    strap <= 1'b1;
    aw <= 16'h5abc;
    repeat (6) @(posedge clk_i);
    chk(csel, 2'h3);
    chk(mode, 1'b0);
    chk(dec, 16'h0abc);
    chk(dec_l, 16'h5abc);
    boot_up(1'b1, 16'hd7e5);
    chk(mode, 1'b1);
    chk(boot, hasd_pkg::BOOT_NONE);
    chk(csel, 2'h0);
    repeat (4) @(posedge clk_i);
    chk(dec, 16'hd7e5);
    wb(1'b0, hasd_pkg::REG_ADDR, 32'h0, 4'hf);
    chk(q, 32'h0000_d7e5);
    wb(1'b1, hasd_pkg::REG_CTRL, 32'h1, 4'h1);
    wb(1'b1, hasd_pkg::REG_DOUT, 32'h5555_a5c3, 4'hf);
    wb(1'b1, hasd_pkg::REG_DOUT, 32'h0000_0011, 4'h1);
    repeat (4) @(posedge clk_i);
    chk(dout, 16'ha511);
    chk(oe, 16'hffff);
    wb(1'b0, hasd_pkg::REG_DIN, 32'h0, 4'hf);
    chk(q, 32'h0000_a511);
    wb(1'b1, hasd_pkg::REG_CTRL, 32'h0, 4'h1);
    dw <= 16'h3c96;
    repeat (4) @(posedge clk_i);
    chk(oe, 16'h0000);
    wb(1'b0, hasd_pkg::REG_DIN, 32'h0, 4'hf);
    chk(q, 32'h0000_3c96);
    wb(1'b0, 8'h20, 32'h0, 4'hf);
    chk(q, 32'h0);
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    wrap_up;
  end
endmodule
